//--- rtl/tcm_consts.svh
/*
  Register indices, field positions, codes and counts for the capture timer.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define TCM_IDX_CONTROL_A     8'h00
`define TCM_IDX_CONTROL_B     8'h01
`define TCM_IDX_EVENT_CONTROL    8'h04
`define TCM_IDX_FLAGS     8'h06
`define TCM_IDX_STATUS    8'h07
`define TCM_IDX_COUNT     8'h0a
`define TCM_IDX_COMPARE   8'h0c
// ==========================================================
// Field positions
`define TCM_A_ENABLE      0
`define TCM_A_CLOCK_SELECT_LO   1
`define TCM_A_CLOCK_SELECT_HI   2
`define TCM_B_MODE_LO     0
`define TCM_B_MODE_HI     2
`define TCM_B_OUT_EN      4
`define TCM_B_OUT_INIT    5
`define TCM_B_ASYNC       6
`define TCM_E_CAPTURE_FLAG_EN     0
`define TCM_E_EDGE        4
`define TCM_E_FILTER      6
`define TCM_F_CAPTURE     0
`define TCM_S_RUN         0
// ==========================================================
// Reset values and counts
`define TCM_RST_BYTE      8'h00
`define TCM_RST_WORD      16'h0000
`define TCM_MAX_COUNT     16'hffff
`define TCM_FILTER_LEN    4
`define TCM_START_DELAY   2'h2
`define TCM_ONE_2B        2'h1
`define TCM_ZERO_2B       2'h0
`endif

//--- rtl/tcm_pkg.sv
/*
  Types shared by the capture timer files.
  Assumes compilation before any module that names these types.
*/
package tcm_pkg;
  // ==========================================================
  // Count modes
  typedef enum logic [2:0] {
    TCM_PERIODIC = 3'b000,
    TCM_TIMEOUT  = 3'b001,
    TCM_CAPTURE  = 3'b010,
    TCM_FREQ     = 3'b011,
    TCM_PULSE    = 3'b100,
    TCM_FREQ_PW  = 3'b101,
    TCM_SINGLE   = 3'b110,
    TCM_PWM8     = 3'b111
  } tcm_mode_t;
  // ==========================================================
  // Timer clock sources
  typedef enum logic [1:0] {
    TCM_CLK_DIV1 = 2'b00,
    TCM_CLK_DIV2 = 2'b01,
    TCM_CLK_NONE = 2'b10,
    TCM_CLK_COMP = 2'b11
  } tcm_clock_select_t;
  // ==========================================================
  // Combined frequency and pulse-width sequence
  typedef enum logic [1:0] {
    TCM_FP_WAIT_RISE = 2'b00,
    TCM_FP_WAIT_FALL = 2'b01,
    TCM_FP_WAIT_STOP = 2'b10,
    TCM_FP_DONE      = 2'b11
  } tcm_fp_t;
endpackage

//--- rtl/tcm_noise_filter.sv
/*
  Event input noise filter: passes a level after FILT_LEN equal samples.
  Assumes a synchronised input on pclk; bypassed when filt_en is low.
*/
`timescale 1ns/100ps
`include "tcm_consts.svh"
module tcm_noise_filter #(
  parameter int FILT_LEN = `TCM_FILTER_LEN
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic filt_en,
  input  wire logic level_in,
  output logic      level_out
);
  logic [FILT_LEN-1:0] hist_q;
  logic                stable_q;

  // ==========================================================
  // Sample history, on the system clock so the prescaler has no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[FILT_LEN-2:0], level_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 1'b0;
    end else if (!filt_en) begin
      stable_q <= level_in;
    end else if (&hist_q || ~|hist_q) begin
      stable_q <= hist_q[0];
    end
  end

  assign level_out = stable_q;

  AST_FILTER_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    filt_en && $past(filt_en) && !(&$past(hist_q) || ~|$past(hist_q))
      |-> $stable(stable_q))
    else $error("Filtered level changed without four equal samples");
endmodule

//--- rtl/tcm_timer.sv
/*
  16-bit capture/compare timer with eight count modes, APB registers,
  event input with optional noise filter and one waveform output.
  Assumes an APB master on pclk, an asynchronous event input and a
  companion timer tick that is a one-cycle pulse on pclk.
*/
// Implementation choices: the APB slave port and the placing of the registers.
// Summary of operation
// - Reset state is periodic mode: count to compare, flag, restart from zero.
// - Compare set below count makes the counter run to maximum and wrap.
// - Timeout mode starts on one event edge, stops on the other edge.
// - Timeout mode flags when the count reaches compare before the stop edge.
// - Frozen timeout restarts on a start edge; run writes are ignored frozen.
// - Capture mode runs freely, copies count to compare on each selected edge, flags.
// - In capture modes reading the compare register clears the flag.
// - Frequency mode captures the count and restarts on the selected edge.
// - Pulse mode restarts on rise, captures on fall and flags; edges spaced two.
// - Combined mode starts on rise, captures on fall, stops and flags next rise.
// - Single-shot: low while stopped; an event restarts counting with output high.
// - Single-shot stops at compare with output low; events ignored for one tick.
// - Synchronous single-shot output rises two timer ticks after the event.
// - Single-shot starts on enable; writing compare value to count prevents it.
// - Asynchronous single-shot sets output for one cycle at once, then again when counting starts ticks later.
// - Eight-bit PWM counts zero to low byte, high until count hits high byte.
// - Output enable drives the waveform onto the pin; otherwise no output.
// - Other modes drive the output initial level bit when enabled.
// - Noise filter passes a level after four equal system clock samples.
// - Clock select: zero undivided, one divided by two, three companion tick.
// - Counter maximum is all ones, where free and wrapping counts turn over.
// - Capture event is a one-cycle pulse under the flag setting conditions.
`timescale 1ns/100ps
`include "tcm_consts.svh"
module tcm_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in,
  input  wire logic        companion_tick,
  output logic             capture_event,
  output logic             waveform_out,
  output logic             waveform_drive
);
  // ==========================================================
  // Registers and state
  logic [7:0]         control_a_q, control_b_q, event_control_q;
  logic [15:0]        count_value_q, capture_compare_value_q;
  logic               capture_flag_q, run_q, hold_q, wave_q, div_q;
  logic               ev_s1_q, ev_s2_q, lvl_q, en_q;
  logic [1:0]         pend_q;
  tcm_pkg::tcm_fp_t   fp_q;
  logic [31:0]        rdata_d;
  logic               ready_q, err_q, cap_evt_q, wout_q, wdrv_q;

  // ==========================================================
  // Decoded controls
  tcm_pkg::tcm_mode_t   mode;
  tcm_pkg::tcm_clock_select_t clock_select;
  logic enable, out_en, async_en, capture_flag_en, edge_sel, filt_en;
  assign mode     = tcm_pkg::tcm_mode_t'(control_b_q[`TCM_B_MODE_HI:`TCM_B_MODE_LO]);
  assign clock_select   = tcm_pkg::tcm_clock_select_t'(control_a_q[`TCM_A_CLOCK_SELECT_HI:`TCM_A_CLOCK_SELECT_LO]);
  assign enable   = control_a_q[`TCM_A_ENABLE];
  assign out_en   = control_b_q[`TCM_B_OUT_EN];
  assign async_en = control_b_q[`TCM_B_ASYNC];
  assign capture_flag_en  = event_control_q[`TCM_E_CAPTURE_FLAG_EN];
  assign edge_sel = event_control_q[`TCM_E_EDGE];
  assign filt_en  = event_control_q[`TCM_E_FILTER];

  // ==========================================================
  // APB decode
  logic [7:0] idx;
  logic       setup, acc, wr, rd, mapped;
  logic       wr_a, wr_b, wr_e, wr_f, wr_s, wr_cnt, wr_cmp, rd_cmp;
  assign idx    = paddr[9:2];
  assign setup  = psel && !penable;
  assign acc    = psel && penable && ready_q;
  assign wr     = acc && pwrite && !err_q;
  assign rd     = acc && !pwrite && !err_q;
  assign wr_a   = wr && idx == `TCM_IDX_CONTROL_A;
  assign wr_b   = wr && idx == `TCM_IDX_CONTROL_B;
  assign wr_e   = wr && idx == `TCM_IDX_EVENT_CONTROL;
  assign wr_f   = wr && idx == `TCM_IDX_FLAGS;
  assign wr_s   = wr && idx == `TCM_IDX_STATUS;
  assign wr_cnt = wr && idx == `TCM_IDX_COUNT;
  assign wr_cmp = wr && idx == `TCM_IDX_COMPARE;
  assign rd_cmp = rd && idx == `TCM_IDX_COMPARE;

  always_comb begin
    rdata_d = 32'h0000_0000;
    mapped  = 1'b1;
    if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx == `TCM_IDX_CONTROL_A) begin
      rdata_d[7:0] = control_a_q;
    end else if (idx == `TCM_IDX_CONTROL_B) begin
      rdata_d[7:0] = control_b_q;
    end else if (idx == `TCM_IDX_EVENT_CONTROL) begin
      rdata_d[7:0] = event_control_q;
    end else if (idx == `TCM_IDX_FLAGS) begin
      rdata_d[`TCM_F_CAPTURE] = capture_flag_q;
    end else if (idx == `TCM_IDX_STATUS) begin
      rdata_d[`TCM_S_RUN] = run_q;
    end else if (idx == `TCM_IDX_COUNT) begin
      rdata_d[15:0] = count_value_q;
    end else if (idx == `TCM_IDX_COMPARE) begin
      rdata_d[15:0] = capture_compare_value_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // Answer one cycle after setup so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      ready_q <= setup;
      err_q   <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end
  assign pready  = ready_q;
  assign pslverr = err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_q     <= `TCM_RST_BYTE;
      control_b_q     <= `TCM_RST_BYTE;
      event_control_q <= `TCM_RST_BYTE;
    end else begin
      if (wr_a) control_a_q <= pwdata[7:0];
      if (wr_b) control_b_q <= pwdata[7:0];
      if (wr_e) event_control_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Timer clock enable
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 1'b0;
    else          div_q <= !div_q;
  end
  always_comb begin
    case (clock_select)
      tcm_pkg::TCM_CLK_DIV1: tick = enable;
      tcm_pkg::TCM_CLK_DIV2: tick = enable && div_q;
      tcm_pkg::TCM_CLK_COMP: tick = enable && companion_tick;
      default:               tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Event input: synchroniser, filter, edge detect
  logic lvl_f, rise, fall, start_e, stop_e;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      lvl_q   <= 1'b0;
      en_q    <= 1'b0;
    end else begin
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
      lvl_q   <= lvl_f;
      en_q    <= enable;
    end
  end

  tcm_noise_filter #(
    .FILT_LEN (`TCM_FILTER_LEN)
  ) u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .filt_en   (filt_en),
    .level_in  (ev_s2_q),
    .level_out (lvl_f)
  );

  assign rise    = enable && capture_flag_en && lvl_f && !lvl_q;
  assign fall    = enable && capture_flag_en && !lvl_f && lvl_q;
  assign start_e = edge_sel ? fall : rise;
  assign stop_e  = edge_sel ? rise : fall;

  // ==========================================================
  // Counter, capture and run state
  logic at_top, set_flag, pwm_end, ss_go, ss_start;
  assign at_top  = count_value_q == capture_compare_value_q;
  assign pwm_end = count_value_q[7:0] >= capture_compare_value_q[7:0];
  assign ss_go   = mode == tcm_pkg::TCM_SINGLE && start_e && !run_q && !hold_q
                   && pend_q == `TCM_ZERO_2B;
  assign ss_start = tick && pend_q == `TCM_ONE_2B;

  always_comb begin
    set_flag = 1'b0;
    case (mode)
      tcm_pkg::TCM_PERIODIC: set_flag = tick && at_top;
      tcm_pkg::TCM_TIMEOUT:  set_flag = tick && run_q && at_top;
      tcm_pkg::TCM_CAPTURE,
      tcm_pkg::TCM_FREQ:     set_flag = start_e;
      tcm_pkg::TCM_PULSE:    set_flag = fall;
      tcm_pkg::TCM_FREQ_PW:  set_flag = rise && fp_q == tcm_pkg::TCM_FP_WAIT_STOP;
      tcm_pkg::TCM_SINGLE:   set_flag = tick && run_q && at_top;
      tcm_pkg::TCM_PWM8:     set_flag = tick && pwm_end;
      default:               set_flag = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= `TCM_RST_WORD;
    end else if (wr_cnt) begin
      count_value_q <= pwdata[15:0];
    end else begin
      case (mode)
        tcm_pkg::TCM_PERIODIC:
          if (tick) count_value_q <= at_top ? `TCM_RST_WORD : count_value_q + 16'h0001;
        tcm_pkg::TCM_TIMEOUT:
          if (start_e && !run_q) count_value_q <= `TCM_RST_WORD;
          else if (tick && run_q) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_CAPTURE:
          if (tick) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_FREQ:
          if (start_e) count_value_q <= `TCM_RST_WORD;
          else if (tick) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_PULSE:
          if (rise) count_value_q <= `TCM_RST_WORD;
          else if (tick) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_FREQ_PW:
          if (rise && fp_q == tcm_pkg::TCM_FP_WAIT_RISE) count_value_q <= `TCM_RST_WORD;
          else if (tick && run_q) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_SINGLE:
          if (ss_start) count_value_q <= `TCM_RST_WORD;
          else if (tick && run_q && !at_top) count_value_q <= count_value_q + 16'h0001;
        tcm_pkg::TCM_PWM8:
          if (tick) count_value_q <= pwm_end ? `TCM_RST_WORD : count_value_q + 16'h0001;
        default: count_value_q <= count_value_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_compare_value_q <= `TCM_RST_WORD;
    end else if (wr_cmp) begin
      capture_compare_value_q <= pwdata[15:0];
    end else if (((mode == tcm_pkg::TCM_CAPTURE || mode == tcm_pkg::TCM_FREQ) && start_e)
                 || (mode == tcm_pkg::TCM_PULSE && fall)
                 || (mode == tcm_pkg::TCM_FREQ_PW && fall
                     && fp_q == tcm_pkg::TCM_FP_WAIT_FALL)) begin
      capture_compare_value_q <= count_value_q;
    end
  end

  // Combined mode sequence; a compare read re-arms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_q <= tcm_pkg::TCM_FP_WAIT_RISE;
    end else if (mode != tcm_pkg::TCM_FREQ_PW || !enable) begin
      fp_q <= tcm_pkg::TCM_FP_WAIT_RISE;
    end else begin
      case (fp_q)
        tcm_pkg::TCM_FP_WAIT_RISE: if (rise) fp_q <= tcm_pkg::TCM_FP_WAIT_FALL;
        tcm_pkg::TCM_FP_WAIT_FALL: if (fall) fp_q <= tcm_pkg::TCM_FP_WAIT_STOP;
        tcm_pkg::TCM_FP_WAIT_STOP: if (rise) fp_q <= tcm_pkg::TCM_FP_DONE;
        default:                   if (rd_cmp) fp_q <= tcm_pkg::TCM_FP_WAIT_RISE;
      endcase
    end
  end

  // Run status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (!enable) begin
      run_q <= 1'b0;
    end else begin
      case (mode)
        tcm_pkg::TCM_TIMEOUT:
          if (start_e && !run_q) run_q <= 1'b1;
          else if (stop_e && run_q) run_q <= 1'b0;
          else if (wr_s && run_q) run_q <= pwdata[`TCM_S_RUN];
        tcm_pkg::TCM_FREQ_PW:
          if (rise && fp_q == tcm_pkg::TCM_FP_WAIT_RISE) run_q <= 1'b1;
          else if (rise && fp_q == tcm_pkg::TCM_FP_WAIT_STOP) run_q <= 1'b0;
        tcm_pkg::TCM_SINGLE:
          if (enable && !en_q) run_q <= 1'b1;
          else if (ss_start) run_q <= 1'b1;
          else if (tick && run_q && at_top) run_q <= 1'b0;
        default: run_q <= 1'b1;
      endcase
    end
  end

  // Single-shot start delay and hold-off after stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= `TCM_ZERO_2B;
      hold_q <= 1'b0;
    end else begin
      if (mode != tcm_pkg::TCM_SINGLE || !enable) pend_q <= `TCM_ZERO_2B;
      else if (ss_go) pend_q <= `TCM_START_DELAY;
      else if (tick && pend_q != `TCM_ZERO_2B) pend_q <= pend_q - `TCM_ONE_2B;
      if (tick && run_q && at_top && mode == tcm_pkg::TCM_SINGLE) hold_q <= 1'b1;
      else if (tick) hold_q <= 1'b0;
    end
  end

  // ==========================================================
  // Capture flag; a set in the clearing cycle wins
  logic clr_flag, capture_flag_mode;
  assign capture_flag_mode = mode == tcm_pkg::TCM_CAPTURE || mode == tcm_pkg::TCM_FREQ
                     || mode == tcm_pkg::TCM_PULSE || mode == tcm_pkg::TCM_FREQ_PW;
  assign clr_flag  = (wr_f && pwdata[`TCM_F_CAPTURE]) || (rd_cmp && capture_flag_mode);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      capture_flag_q <= 1'b0;
    else if (set_flag) capture_flag_q <= 1'b1;
    else if (clr_flag) capture_flag_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cap_evt_q <= 1'b0;
    else          cap_evt_q <= set_flag;
  end
  assign capture_event = cap_evt_q;

  // ==========================================================
  // Waveform generation and pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 1'b0;
    end else begin
      case (mode)
        tcm_pkg::TCM_SINGLE:
          // Asynchronous mode skips the timer clock, not the synchroniser
          if (ss_go && async_en) wave_q <= 1'b1;
          else if (ss_start) wave_q <= 1'b1;
          else if (!run_q || (tick && at_top)) wave_q <= 1'b0;
        tcm_pkg::TCM_PWM8:
          // High byte counts high ticks, so clear as the count arrives there
          if (tick && pwm_end) wave_q <= capture_compare_value_q[15:8] != `TCM_RST_BYTE;
          else if (tick && 8'(count_value_q[7:0] + 8'h01) == capture_compare_value_q[15:8])
            wave_q <= 1'b0;
        default: wave_q <= control_b_q[`TCM_B_OUT_INIT];
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wout_q <= 1'b0;
      wdrv_q <= 1'b0;
    end else begin
      // Initial level read directly so drive and level rise together
      wout_q <= out_en && ((mode == tcm_pkg::TCM_SINGLE || mode == tcm_pkg::TCM_PWM8)
                           ? wave_q : control_b_q[`TCM_B_OUT_INIT]);
      wdrv_q <= out_en;
    end
  end
  assign waveform_out   = wout_q;
  assign waveform_drive = wdrv_q;

  // ==========================================================
  // Checks
  sequence s_ss_event;
    ss_go && !async_en;
  endsequence

  AST_PERIODIC_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_PERIODIC && tick && at_top && !wr_cnt
      |=> count_value_q == `TCM_RST_WORD && capture_event)
    else $error("Periodic mode did not restart at compare");
  AST_MAX_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_PERIODIC && tick && !at_top && count_value_q == `TCM_MAX_COUNT
      && !wr_cnt |=> count_value_q == `TCM_RST_WORD)
    else $error("Counter did not wrap at maximum");
  AST_CAPTURE_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_CAPTURE && start_e && !wr_cmp
      |=> capture_compare_value_q == $past(count_value_q) && capture_flag_q)
    else $error("Capture did not copy count");
  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cmp && capture_flag_mode && !set_flag |=> !capture_flag_q)
    else $error("Compare read did not clear flag");
  AST_FREQ_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_FREQ && start_e && !wr_cnt |=> count_value_q == `TCM_RST_WORD)
    else $error("Frequency mode did not restart");
  AST_TIMEOUT_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_TIMEOUT && !run_q && !start_e && $stable(control_b_q) && enable
      |=> !run_q)
    else $error("Frozen timeout began to run without a start edge");
  AST_SS_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    s_ss_event ##1 (!tick && mode == tcm_pkg::TCM_SINGLE) [*2] |-> !wave_q)
    else $error("Single-shot output rose before two ticks");
  AST_SS_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    mode == tcm_pkg::TCM_SINGLE && tick && run_q && at_top && enable
      |=> !run_q && !wave_q && hold_q)
    else $error("Single-shot did not stop at compare");
  AST_EVENT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    capture_event |-> capture_flag_q)
    else $error("Capture event without flag");
  AST_NO_OUTPUT: assert property (@(posedge pclk) disable iff (!presetn)
    !out_en ##1 !out_en |-> !waveform_out && !waveform_drive)
    else $error("Waveform driven while disabled");
endmodule

//--- test/tcm_far_end.sv
/*
  Far-end model: event channel source and the waveform pin.
  Assumes the bench sets want off the clock edge; pin has a pull-up.
*/
`timescale 1ns/100ps
module tcm_far_end (
  input  wire logic pclk,
  input  wire logic want,
  input  wire logic waveform_out,
  input  wire logic waveform_drive,
  output logic      event_in,
  output logic      pin
);
  // ==========================================================
  // Event source
  logic [2:0] hold_q;
  initial event_in = 1'b0;
  initial hold_q = 3'h0;
  always @(posedge pclk) begin
    if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else if (want != event_in) begin
      event_in <= want;
      hold_q   <= 3'h6;
    end
  end
  // Released pin rests high
  assign pin = waveform_drive ? waveform_out : 1'b1;
endmodule

//--- test/tcm_timer_tb.sv
/*
  Bench for the capture timer: APB tasks, queued expected answers, watcher.
  Assumes the timer design, its constants header and the far-end model.
*/
`timescale 1ns/100ps
`include "tcm_consts.svh"
module tcm_timer_tb;
  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, want, tick, pready, pslverr;
  logic capture_event, waveform_out, waveform_drive, event_in, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [65:0] q[$];
  logic [65:0] cur;
  logic [15:0] r;
  int failures, comparisons, i, cs, m;
  tcm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .companion_tick(tick),
    .capture_event(capture_event), .waveform_out(waveform_out),
    .waveform_drive(waveform_drive));
  tcm_far_end far_u (.pclk(pclk), .want(want), .waveform_out(waveform_out),
    .waveform_drive(waveform_drive), .event_in(event_in), .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Companion tick at half rate
  always @(posedge pclk) tick <= ~tick;
  // ==========================================================
  // Tasks
  task cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [65:0] e);
    q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {33'h100000000, 33'h0});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0, {{33{1'b1}}, 1'b0, v});
  endtask
  task hi(input int n, input int e);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin === 1'b1) h++;
    end
    cmp("pin_high", 33'(e), 33'(h));
  endtask
  task gap(input int e);
    int k;
    k = 0;
    while (capture_event !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    k = 1;
    while (capture_event !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    cmp("event_gap", 33'(e), 33'(k));
  endtask
  task stop_test;
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Watcher of APB answers
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q.size() > 0) begin
      cur = q.pop_front();
      cmp("apb", cur[32:0] & cur[65:33], {pslverr, prdata} & cur[65:33]);
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    stop_test;
  end
  // ==========================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, want, tick, paddr, pwdata} = '0;
    failures = 0;
    comparisons = 0;
    void'($urandom(32'hc874));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`TCM_IDX_CONTROL_A, 32'h0);
    rd(`TCM_IDX_CONTROL_B, 32'h0);
    apb(1'b0, 8'h02, 32'h0, {2{33'h100000000}});
    r = 16'($urandom);
    wr(`TCM_IDX_COUNT, {16'h0, r});
    rd(`TCM_IDX_COUNT, {16'h0, r});
    wr(`TCM_IDX_COUNT, 32'h0);
    wr(`TCM_IDX_COMPARE, 32'h5);
    wr(`TCM_IDX_CONTROL_A, 32'h1);
    gap(6);
    rd(`TCM_IDX_FLAGS, 32'h1);
    wr(`TCM_IDX_CONTROL_A, 32'h0);
    wr(`TCM_IDX_COUNT, 32'h10);
    wr(`TCM_IDX_FLAGS, 32'h1);
    wr(`TCM_IDX_CONTROL_A, 32'h1);
    repeat (20) @(posedge pclk);
    rd(`TCM_IDX_FLAGS, 32'h0);
    wr(`TCM_IDX_CONTROL_A, 32'h0);
    wr(`TCM_IDX_CONTROL_B, 32'h2);
    wr(`TCM_IDX_EVENT_CONTROL, 32'h1);
    wr(`TCM_IDX_COUNT, 32'h0);
    wr(`TCM_IDX_FLAGS, 32'h1);
    wr(`TCM_IDX_CONTROL_A, 32'h1);
    want <= 1'b1;
    repeat (12) @(posedge pclk);
    rd(`TCM_IDX_FLAGS, 32'h1);
    rd(`TCM_IDX_COMPARE, 32'h5);
    rd(`TCM_IDX_FLAGS, 32'h0);
    // ==========================================================
    // Combined mode: rise, fall, rise ten cycles apart
    wr(`TCM_IDX_CONTROL_A, 32'h0);
    want <= 1'b0;
    wr(`TCM_IDX_CONTROL_B, 32'h5);
    wr(`TCM_IDX_FLAGS, 32'h1);
    wr(`TCM_IDX_CONTROL_A, 32'h1);
    for (i = 0; i < 3; i++) begin
      want <= ~want;
      repeat (10) @(posedge pclk);
    end
    rd(`TCM_IDX_COUNT, 32'h14);
    rd(`TCM_IDX_FLAGS, 32'h1);
    rd(`TCM_IDX_COMPARE, 32'h9);
    rd(`TCM_IDX_FLAGS, 32'h0);
    wr(`TCM_IDX_CONTROL_A, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(`TCM_IDX_CONTROL_B, i ? 32'h10 : 32'h30);
      hi(8, i ? 0 : 8);
    end
    wr(`TCM_IDX_CONTROL_B, 32'h0);
    @(posedge pclk);
    cmp("drive", 33'h0, {32'h0, waveform_drive});
    // ==========================================================
    // Single-shot: count parked at compare, then one event
    want <= 1'b0;
    wr(`TCM_IDX_COMPARE, 32'h8);
    wr(`TCM_IDX_COUNT, 32'h8);
    wr(`TCM_IDX_CONTROL_B, 32'h16);
    wr(`TCM_IDX_CONTROL_A, 32'h1);
    wr(`TCM_IDX_FLAGS, 32'h1);
    rd(`TCM_IDX_STATUS, 32'h0);
    want <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(`TCM_IDX_STATUS, 32'h1);
    repeat (10) @(posedge pclk);
    rd(`TCM_IDX_FLAGS, 32'h1);
    rd(`TCM_IDX_STATUS, 32'h0);
    hi(4, 0);
    for (cs = 0; cs < 4; cs++) begin
      if (cs != 2) begin
        m = (cs == 0) ? 1 : 2;
        wr(`TCM_IDX_CONTROL_A, 32'h0);
        wr(`TCM_IDX_COUNT, 32'h0);
        wr(`TCM_IDX_COMPARE, 32'h0103);
        wr(`TCM_IDX_CONTROL_B, 32'h17);
        wr(`TCM_IDX_CONTROL_A, 32'(cs * 2 + 1));
        repeat (8) @(posedge pclk);
        hi(40 * m, 10 * m);
      end
    end
    cmp("queue", 33'h0, 33'(q.size()));
    stop_test;
  end
endmodule
